// ===== rtl/etx_overhead_mux.sv
// e1 transmit overhead source selection with wishbone control
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - with frame sync select set, the frame and multiframe sync pins are used as inputs; field resets to zero.
// - in system timing a new frame starts whenever the frame sync input is sampled high on the link clock.
// - a two-bit data link source field, reset zero, picks among three sources of data-link bits.
// - data link source code 01 takes the data-link bits from the hdlc controller.
// - with crc source bit zero the crc-4 bits are computed internally and inserted.
// - with crc source bit one the serial input bits are copied into the crc-4 positions.
// - the crc source bit is ignored while crc multiframe alignment is disabled.
// - with alignment source bit zero the fas, multiframe alignment, e and a bits are generated.
// - with alignment source bit one the serial input is copied into those positions.
// - the e-bit source field acts only while alignment bits are generated internally.
// - e-bit codes: 00 crc error report, 01 all zero, 10 all one, 11 data link.
module etx_overhead_mux (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [7:0] wb_dat_in,
	input wire logic wb_sel_in,
	output logic [7:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic tx_serial_clock,
	input wire logic tx_link_reset_n_in,
	input wire logic tx_serial_data_in,
	input wire logic tx_frame_sync_in,
	input wire logic tx_multiframe_sync_in,
	input wire logic crc_mf_enable_in,
	input wire logic hdlc_bit_in,
	input wire logic overhead_bit_in,
	input wire logic rx_crc_error_in,
	input wire logic remote_alarm_in,
	output logic tx_data_out,
	output logic tx_frame_start_out
);
	// ----------------------------------------
	// register bus side
	// ----------------------------------------
	logic [7:0] ctrl_reg;
	logic [7:0] status_sys_reg;
	logic ack_reg;
	logic [7:0] rdata_reg;
	logic bus_req;
	logic ctrl_write;
	logic [7:0] rdata_next;
	assign bus_req = wb_cyc_in && wb_stb_in && !ack_reg;
	// writes land at the edge where the master sees ack, not one earlier
	assign ctrl_write = wb_cyc_in && wb_stb_in && ack_reg && wb_we_in && wb_sel_in
		&& wb_adr_in == etx_pkg::SYNC_MUX_CTRL_ADDR;
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ctrl_reg <= etx_pkg::SYNC_MUX_CTRL_RESET;
		end else if (ctrl_write) begin
			// bit 5 reserved, reads zero
			ctrl_reg <= wb_dat_in & etx_pkg::CTRL_WRITE_MASK;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			ack_reg <= bus_req;
			if (bus_req) begin
				rdata_reg <= rdata_next;
			end
		end
	end
	// ----------------------------------------
	// read path
	// ----------------------------------------
	// unmapped words read zero so software can probe the map safely
	always_comb begin
		case (wb_adr_in)
			etx_pkg::SYNC_MUX_CTRL_ADDR: rdata_next = ctrl_reg;
			etx_pkg::TX_STATUS_ADDR: rdata_next = status_sys_reg;
			default: rdata_next = 8'h00;
		endcase
	end
	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rdata_reg;
	// ----------------------------------------
	// control into link domain
	// ----------------------------------------
	// quasi-static settings; each bit crosses on its own, so change them while idle
	logic [7:0] ctrl_link;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_ctl
			etx_sync3 u_sync (
				.clk_in(tx_serial_clock),
				.d_in(ctrl_reg[gi]),
				.q_out(ctrl_link[gi])
			);
		end
	endgenerate
	logic ext_timing;
	logic crc_ext;
	logic fas_ext;
	logic [1:0] dl_src;
	logic [1:0] ebit_src;
	logic [7:0] ctrl_frame_reg;
	logic crc_mf_link;
	logic crc_mf_frame_reg;
	// sync pulses must be honoured at once, so frame select skips the frame copy
	assign ext_timing = ctrl_link[etx_pkg::FSYNC_SEL_BIT];
	assign crc_ext = ctrl_frame_reg[etx_pkg::CRC_SRC_BIT];
	assign fas_ext = ctrl_frame_reg[etx_pkg::FAS_SRC_BIT];
	assign dl_src = ctrl_frame_reg[etx_pkg::DL_SRC_LO +: 2];
	assign ebit_src = ctrl_frame_reg[etx_pkg::EBIT_SRC_LO +: 2];
	// ----------------------------------------
	// link-domain level inputs
	// ----------------------------------------
	// multiframe enable comes from the bus side, not the link clock
	etx_sync3 u_sync_crc_mf (
		.clk_in(tx_serial_clock),
		.d_in(crc_mf_enable_in),
		.q_out(crc_mf_link)
	);
	// ----------------------------------------
	// frame timing
	// ----------------------------------------
	logic [7:0] bit_cnt_reg;
	logic [3:0] frame_cnt_reg;
	logic fsync_d_reg;
	logic msync_d_reg;
	logic frame_start;
	always_ff @(posedge tx_serial_clock) begin
		if (!tx_link_reset_n_in) begin
			fsync_d_reg <= 1'b0;
			msync_d_reg <= 1'b0;
		end else begin
			// sync pulses outside external timing are dropped here
			fsync_d_reg <= tx_frame_sync_in && ext_timing;
			msync_d_reg <= tx_multiframe_sync_in && ext_timing;
		end
	end
	always_ff @(posedge tx_serial_clock) begin
		if (!tx_link_reset_n_in) begin
			bit_cnt_reg <= 8'h00;
			frame_cnt_reg <= 4'h0;
		end else if (fsync_d_reg) begin
			bit_cnt_reg <= 8'h00;
			if (msync_d_reg || frame_cnt_reg == etx_pkg::FRAMES_PER_MF_LAST) begin
				frame_cnt_reg <= 4'h0;
			end else begin
				frame_cnt_reg <= frame_cnt_reg + 4'h1;
			end
		end else if (bit_cnt_reg == etx_pkg::BITS_PER_FRAME_LAST) begin
			// free-running in internal timing; also flywheels between external pulses
			bit_cnt_reg <= 8'h00;
			frame_cnt_reg <= frame_cnt_reg + 4'h1;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 8'h01;
		end
	end
	assign frame_start = (bit_cnt_reg == 8'h00);
	// ----------------------------------------
	// frame-aligned copy of the selects
	// ----------------------------------------
	// bits cross one by one; latching at frame start keeps one frame on one setting
	always_ff @(posedge tx_serial_clock) begin
		if (!tx_link_reset_n_in) begin
			ctrl_frame_reg <= etx_pkg::SYNC_MUX_CTRL_RESET;
			crc_mf_frame_reg <= 1'b0;
		end else if (frame_start) begin
			ctrl_frame_reg <= ctrl_link;
			crc_mf_frame_reg <= crc_mf_link;
		end
	end
	// ----------------------------------------
	// timeslot 0 positions
	// ----------------------------------------
	logic fas_frame;
	logic in_ts0;
	logic [2:0] ts0_bit;
	assign fas_frame = !frame_cnt_reg[0];
	assign in_ts0 = (bit_cnt_reg[7:3] == 5'h00);
	assign ts0_bit = bit_cnt_reg[2:0];
	logic pos_si;
	logic pos_fas;
	logic pos_nfas_one;
	logic pos_abit;
	logic pos_sa;
	assign pos_si = in_ts0 && ts0_bit == 3'h0;
	assign pos_fas = in_ts0 && fas_frame && ts0_bit != 3'h0;
	assign pos_nfas_one = in_ts0 && !fas_frame && ts0_bit == 3'h1;
	assign pos_abit = in_ts0 && !fas_frame && ts0_bit == 3'h2;
	assign pos_sa = in_ts0 && !fas_frame && ts0_bit > 3'h2;
	logic pos_crc;
	logic pos_mfas;
	logic pos_ebit;
	assign pos_crc = pos_si && fas_frame;
	assign pos_mfas = pos_si && !fas_frame && frame_cnt_reg < 4'hc;
	assign pos_ebit = pos_si && !fas_frame && frame_cnt_reg >= 4'hc;
	// ----------------------------------------
	// crc-4 over previous sub-multiframe
	// ----------------------------------------
	logic [3:0] crc_acc_reg;
	logic [3:0] crc_hold_reg;
	logic crc_in_bit;
	logic smf_start;
	assign smf_start = frame_start && frame_cnt_reg[2:0] == 3'h0;
	logic out_next;
	// the outgoing bit, c positions as zero, enters the sum in step with the counter
	assign crc_in_bit = pos_crc ? 1'b0 : out_next;
	// x^4 + x + 1; c bits are zeroed in the sum, as g.704 asks
	always_ff @(posedge tx_serial_clock) begin
		if (!tx_link_reset_n_in) begin
			crc_acc_reg <= 4'h0;
			crc_hold_reg <= 4'h0;
		end else if (smf_start) begin
			crc_hold_reg <= crc_acc_reg;
			crc_acc_reg <= 4'h0;
		end else begin
			crc_acc_reg <= {crc_acc_reg[2:0], 1'b0}
				^ ((crc_acc_reg[3] ^ crc_in_bit) ? 4'h3 : 4'h0);
		end
	end
	// ----------------------------------------
	// overhead bit generation
	// ----------------------------------------
	logic mf_align_bit;
	logic ebit_val;
	logic dl_bit;
	logic crc_bit;
	logic gen_bit;
	logic fas_word_bit;
	// multiframe word 001011 rides in the si bits of the first six odd frames
	always_comb begin
		case (frame_cnt_reg[3:1])
			3'h2: mf_align_bit = 1'b1;
			3'h4: mf_align_bit = 1'b1;
			3'h5: mf_align_bit = 1'b1;
			default: mf_align_bit = 1'b0;
		endcase
	end
	always_comb begin
		case (dl_src)
			etx_pkg::DL_SRC_HDLC: dl_bit = hdlc_bit_in;
			etx_pkg::DL_SRC_OVERHEAD: dl_bit = overhead_bit_in;
			default: dl_bit = tx_serial_data_in;
		endcase
	end
	always_comb begin
		case (ebit_src)
			etx_pkg::EBIT_CRC_REPORT: ebit_val = !rx_crc_error_in;
			etx_pkg::EBIT_ZERO: ebit_val = 1'b0;
			etx_pkg::EBIT_ONE: ebit_val = 1'b1;
			etx_pkg::EBIT_DATALINK: ebit_val = dl_bit;
			default: ebit_val = 1'b1;
		endcase
	end
	always_comb begin
		case (frame_cnt_reg[2:1])
			2'h0: crc_bit = crc_hold_reg[3];
			2'h1: crc_bit = crc_hold_reg[2];
			2'h2: crc_bit = crc_hold_reg[1];
			default: crc_bit = crc_hold_reg[0];
		endcase
	end
	// alignment word 0011011 in bits two to eight
	always_comb begin
		case (ts0_bit)
			3'h1: fas_word_bit = 1'b0;
			3'h2: fas_word_bit = 1'b0;
			3'h5: fas_word_bit = 1'b0;
			default: fas_word_bit = 1'b1;
		endcase
	end
	// si bits idle at one when the multiframe is off
	always_comb begin
		gen_bit = 1'b1;
		if (pos_crc && crc_mf_frame_reg) begin
			gen_bit = crc_bit;
		end else if (pos_mfas && crc_mf_frame_reg) begin
			gen_bit = mf_align_bit;
		end else if (pos_ebit && crc_mf_frame_reg) begin
			gen_bit = ebit_val;
		end else if (pos_fas) begin
			gen_bit = fas_word_bit;
		end else if (pos_nfas_one) begin
			gen_bit = 1'b1;
		end else if (pos_abit) begin
			gen_bit = remote_alarm_in;
		end
	end
	always_comb begin
		out_next = tx_serial_data_in;
		if (pos_crc && crc_mf_frame_reg) begin
			// crc positions follow their own select only when multiframe is on
			out_next = crc_ext ? tx_serial_data_in : gen_bit;
		end else if (pos_si || pos_fas || pos_nfas_one || pos_abit) begin
			out_next = fas_ext ? tx_serial_data_in : gen_bit;
		end else if (pos_sa) begin
			out_next = dl_bit;
		end
	end
	always_ff @(posedge tx_serial_clock) begin
		if (!tx_link_reset_n_in) begin
			tx_data_out <= 1'b1;
			tx_frame_start_out <= 1'b0;
		end else begin
			tx_data_out <= out_next;
			tx_frame_start_out <= frame_start;
		end
	end
	// ----------------------------------------
	// status back to bus domain
	// ----------------------------------------
	logic mf_toggle_reg;
	logic mf_toggle_sys;
	logic ext_timing_sys;
	always_ff @(posedge tx_serial_clock) begin
		if (!tx_link_reset_n_in) begin
			mf_toggle_reg <= 1'b0;
		end else if (frame_start && frame_cnt_reg == 4'h0) begin
			mf_toggle_reg <= !mf_toggle_reg;
		end
	end
	etx_sync3 u_sync_mf (
		.clk_in(clk_in),
		.d_in(mf_toggle_reg),
		.q_out(mf_toggle_sys)
	);
	etx_sync3 u_sync_ext (
		.clk_in(clk_in),
		.d_in(ext_timing),
		.q_out(ext_timing_sys)
	);
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			status_sys_reg <= 8'h00;
		end else begin
			status_sys_reg <= {6'h00, mf_toggle_sys, ext_timing_sys};
		end
	end
endmodule
`default_nettype wire

// ===== rtl/etx_pkg.sv
// constants for the e1 transmit overhead source mux
package etx_pkg;
	// ----------------------------------------
	// register map (word offsets on wishbone)
	// ----------------------------------------
	localparam logic [3:0] SYNC_MUX_CTRL_ADDR = 4'h0;
	localparam logic [3:0] TX_STATUS_ADDR = 4'h4;
	localparam logic [7:0] SYNC_MUX_CTRL_RESET = 8'h00;
	// ----------------------------------------
	// sync_source_mux_control fields
	// ----------------------------------------
	localparam int FAS_SRC_BIT = 0;
	localparam int CRC_SRC_BIT = 1;
	localparam int DL_SRC_LO = 2;
	localparam int FSYNC_SEL_BIT = 4;
	localparam int EBIT_SRC_LO = 6;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'hdf;
	// ----------------------------------------
	// codes
	// ----------------------------------------
	localparam logic [1:0] DL_SRC_HDLC = 2'h1;
	localparam logic [1:0] DL_SRC_OVERHEAD = 2'h2;
	localparam logic [1:0] EBIT_CRC_REPORT = 2'h0;
	localparam logic [1:0] EBIT_ZERO = 2'h1;
	localparam logic [1:0] EBIT_ONE = 2'h2;
	localparam logic [1:0] EBIT_DATALINK = 2'h3;
	// ----------------------------------------
	// e1 frame geometry
	// ----------------------------------------
	localparam logic [7:0] BITS_PER_FRAME_LAST = 8'hff;
	localparam logic [3:0] FRAMES_PER_MF_LAST = 4'hf;
endpackage

// ===== rtl/etx_sync3.sv
// three-flop synchroniser for one level crossing into a clock domain
`timescale 1ns/1ns
`default_nettype none
module etx_sync3 (
	input wire logic clk_in,
	input wire logic d_in,
	output logic q_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	// only s2 and s3 are looked at; a change counts once they agree
	always_ff @(posedge clk_in) begin
		s1_reg <= d_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		if (s2_reg == s3_reg) begin
			q_out <= s3_reg;
		end
	end
endmodule
`default_nettype wire

// ===== tb/etx_overhead_mux_monitor.sv
// port checker for the e1 overhead mux
`timescale 1ns/1ns
`default_nettype none
module etx_overhead_mux_monitor (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [7:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire logic tx_serial_clock,
	input wire logic tx_link_reset_n_in,
	input wire logic tx_frame_sync_in,
	input wire logic tx_data_out,
	input wire logic tx_frame_start_out
);
	// link cycles since the last frame start; seen gates the first one after reset
	logic [8:0] gap_reg;
	logic seen_reg;
	always_ff @(posedge tx_serial_clock) begin
		if (!tx_link_reset_n_in) begin
			gap_reg <= 9'h000;
			seen_reg <= 1'b0;
		end else if (tx_frame_start_out) begin
			gap_reg <= 9'h000;
			seen_reg <= 1'b1;
		end else begin
			gap_reg <= gap_reg + 9'h001;
		end
	end
	chk_ack_latency: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
	chk_ack_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wb_ack_out |=> !wb_ack_out) else $error("ack too long");
	chk_bus_reset: assert property (@(posedge clk_in)
		!reset_n_in |=> !wb_ack_out && wb_dat_out == 8'h00) else $error("bus reset");
	chk_rsvd_bit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wb_ack_out && !wb_we_in |-> !wb_dat_out[5]) else $error("bit5 set");
	chk_unmapped_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wb_ack_out && !wb_we_in && wb_adr_in != etx_pkg::SYNC_MUX_CTRL_ADDR
		&& wb_adr_in != etx_pkg::TX_STATUS_ADDR |-> wb_dat_out == 8'h00)
		else $error("unmapped read");
	chk_link_reset: assert property (@(posedge tx_serial_clock)
		!tx_link_reset_n_in |=> tx_data_out && !tx_frame_start_out) else $error("link reset");
	chk_start_pulse: assert property (@(posedge tx_serial_clock) disable iff (!tx_link_reset_n_in)
		tx_frame_start_out |=> !tx_frame_start_out) else $error("start too long");
	// a start comes either from the 256-bit flywheel or from a sampled sync pulse
	chk_frame_timing: assert property (@(posedge tx_serial_clock) disable iff (!tx_link_reset_n_in)
		seen_reg && tx_frame_start_out |-> gap_reg == 9'h0ff || $past(tx_frame_sync_in)
		|| $past(tx_frame_sync_in, 2) || $past(tx_frame_sync_in, 3) || $past(tx_frame_sync_in, 4))
		else $error("frame start off");
endmodule
bind etx_overhead_mux etx_overhead_mux_monitor u_mon (.clk_in, .reset_n_in, .wb_cyc_in,
	.wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .tx_serial_clock,
	.tx_link_reset_n_in, .tx_frame_sync_in, .tx_data_out, .tx_frame_start_out);
`default_nettype wire

// ===== tb/etx_sys_model.sv
// system-side terminal equipment: serial data and sync pulses
`timescale 1ns/1ns
`default_nettype none
module etx_sys_model (
	input wire logic clk_in,
	input wire logic level_in,
	input wire logic fire_in,
	output logic data_out,
	output logic fsync_out,
	output logic msync_out
);
	logic fire_reg = 1'b0;
	initial data_out = 1'b1;
	initial fsync_out = 1'b0;
	initial msync_out = 1'b0;
	// a toggle on fire_in gives exactly one frame and one multiframe sync pulse, each one link cycle wide
	always @(posedge clk_in) begin
		data_out <= level_in;
		fsync_out <= fire_in ^ fire_reg;
		msync_out <= fire_in ^ fire_reg;
		fire_reg <= fire_in;
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the e1 overhead mux
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk_in = 1'b0, tx_serial_clock = 1'b0, reset_n_in = 1'b0, tx_link_reset_n_in = 1'b0;
	logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_sel_in = 1'b0;
	logic [3:0] wb_adr_in = 4'h0;
	logic [7:0] wb_dat_in = 8'h00;
	logic crc_mf_enable_in = 1'b0, hdlc_bit_in = 1'b0, overhead_bit_in = 1'b0;
	logic rx_crc_error_in = 1'b0, remote_alarm_in = 1'b0, level = 1'b1, fire = 1'b0;
	logic wb_ack_out, tx_data_out, tx_frame_start_out;
	logic tx_serial_data_in, tx_frame_sync_in, tx_multiframe_sync_in;
	logic [7:0] wb_dat_out, cur, rd, v;
	logic [7:0] hist [16];
	logic [1:0] dl_mode = 2'h0;
	logic sa_on = 1'b0, dl_exp = 1'b0;
	int seed = 32'h75099e89;
	int failures = 0, n_checks = 0, pos = 255, nfs = 0, nfr = 0, n0;
	always #20 clk_in = ~clk_in;
	always begin
		#7 tx_serial_clock = ~tx_serial_clock;
		#8 tx_serial_clock = ~tx_serial_clock;
	end
	etx_overhead_mux DUT (.clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
		.wb_dat_in, .wb_sel_in, .wb_dat_out, .wb_ack_out, .tx_serial_clock, .tx_link_reset_n_in,
		.tx_serial_data_in, .tx_frame_sync_in, .tx_multiframe_sync_in, .crc_mf_enable_in,
		.hdlc_bit_in, .overhead_bit_in, .rx_crc_error_in, .remote_alarm_in, .tx_data_out,
		.tx_frame_start_out);
	etx_sys_model u_sys (.clk_in(tx_serial_clock), .level_in(level), .fire_in(fire),
		.data_out(tx_serial_data_in), .fsync_out(tx_frame_sync_in), .msync_out(tx_multiframe_sync_in));
	always @(posedge tx_serial_clock)
		{hdlc_bit_in, overhead_bit_in, rx_crc_error_in, remote_alarm_in} <= 4'($random(seed));
	// keeps timeslot-0 bits of the last 16 frames, first bit in the msb
	always @(posedge tx_serial_clock) begin
		if (tx_frame_start_out === 1'b1) begin
			pos = 0;
			nfs++;
		end else if (pos < 255) begin
			pos++;
		end
		if (pos < 8)
			cur[7 - pos] = tx_data_out;
		if (pos == 7) begin
			hist[nfr % 16] = cur;
			nfr++;
		end
		// sa bits of frames without the alignment word carry the chosen source
		if (sa_on && pos >= 3 && pos < 8 && cur[6] === 1'b1)
			chk({7'h00, tx_data_out}, {7'h00, dl_exp});
		dl_exp = dl_mode == 2'h1 ? hdlc_bit_in : dl_mode == 2'h2 ? overhead_bit_in : tx_serial_data_in;
	end
	task automatic stop_test();
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d, input logic s);
		@(posedge clk_in);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, wb_sel_in} <= {2'h3, we, a, d, s};
		do @(posedge clk_in); while (wb_ack_out !== 1'b1);
		rd = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'h0;
	endtask
	// new control value, then enough frames for the crossing and a full history
	task automatic setc(input logic [7:0] c, input logic l);
		level <= l;
		wb(1'b1, etx_pkg::SYNC_MUX_CTRL_ADDR, c, 1'b1);
		repeat (18) @(posedge tx_frame_start_out);
	endtask
	// frames with the alignment word; with crc on, only those whose first bit is c
	function automatic logic [7:0] fas_cnt(input logic crc_on, input logic c);
		logic [7:0] n = 8'h00;
		for (int i = 0; i < 16; i++)
			if (hist[i][6:0] == 7'h1b && (!crc_on || hist[i][7] === c))
				n++;
		return n;
	endfunction
	// frames without the alignment word whose first bit is one
	function automatic logic [7:0] nfas_ones();
		logic [7:0] n = 8'h00;
		for (int i = 0; i < 16; i++)
			if (hist[i][6] === 1'b1 && hist[i][7] === 1'b1)
				n++;
		return n;
	endfunction
	// sync pulse mid-frame, away from any natural frame boundary
	task automatic pulse(input logic [7:0] e);
		do @(posedge tx_serial_clock); while (pos != 100);
		n0 = nfs;
		fire <= ~fire;
		repeat (8) @(posedge tx_serial_clock);
		chk(8'(nfs - n0), e);
	endtask
	initial begin
		#1500000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge tx_serial_clock);
		tx_link_reset_n_in <= 1'b1;
		wb(1'b0, etx_pkg::SYNC_MUX_CTRL_ADDR, 8'h00, 1'b1);
		chk(rd, etx_pkg::SYNC_MUX_CTRL_RESET);
		wb(1'b0, 4'h8, 8'h00, 1'b1);
		chk(rd, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wb(1'b1, etx_pkg::SYNC_MUX_CTRL_ADDR, v, 1'b1);
			wb(1'b0, etx_pkg::SYNC_MUX_CTRL_ADDR, 8'h00, 1'b1);
			chk(rd, v & etx_pkg::CTRL_WRITE_MASK);
		end
		wb(1'b1, etx_pkg::SYNC_MUX_CTRL_ADDR, ~v, 1'b0);
		wb(1'b0, etx_pkg::SYNC_MUX_CTRL_ADDR, 8'h00, 1'b1);
		chk(rd, v & etx_pkg::CTRL_WRITE_MASK);
		crc_mf_enable_in <= 1'b1;
		setc(8'h00, 1'b1);
		chk(fas_cnt(1'b0, 1'b0), 8'h08);
		setc(8'h01, 1'b1);
		chk(fas_cnt(1'b0, 1'b0), 8'h00);
		v[0] = 1'($random(seed));
		setc(8'h02, v[0]);
		chk(fas_cnt(1'b1, v[0]), 8'h08);
		setc(8'h40, 1'b1);
		chk(nfas_ones(), 8'h03);
		setc(8'h80, 1'b1);
		chk(nfas_ones(), 8'h05);
		v[0] = 1'($random(seed));
		setc(8'hc0, v[0]);
		chk(nfas_ones(), v[0] ? 8'h05 : 8'h03);
		for (int m = 1; m < 3; m++) begin
			dl_mode = 2'(m);
			setc(8'(m << etx_pkg::DL_SRC_LO), 1'b1);
			sa_on = 1'b1;
			repeat (4) @(posedge tx_frame_start_out);
			sa_on = 1'b0;
		end
		@(posedge clk_in);
		crc_mf_enable_in <= 1'b0;
		setc(8'h02, 1'b0);
		chk(fas_cnt(1'b1, 1'b1), 8'h08);
		setc(8'h10, 1'b1);
		wb(1'b0, etx_pkg::TX_STATUS_ADDR, 8'h00, 1'b1);
		chk(rd & 8'h01, 8'h01);
		pulse(8'h01);
		setc(8'h00, 1'b1);
		wb(1'b0, etx_pkg::TX_STATUS_ADDR, 8'h00, 1'b1);
		chk(rd & 8'h01, 8'h00);
		pulse(8'h00);
		stop_test();
	end
endmodule
`default_nettype wire
